// ==== inc/spw_pkg.sv ====
// shared constants and carrier types of the soft power wake-up block
package spw_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_OFF_DELAY  = 8'hB8;
  localparam logic [7:0] IDX_STEER_TWO  = 8'hEF;
  localparam logic [7:0] IDX_STEER_ONE  = 8'hF0;
  localparam logic [7:0] IDX_WDOG_CTRL  = 8'hF1;
  localparam logic [7:0] IDX_SPW_EN_ONE = 8'hF2;
  localparam logic [7:0] IDX_SPW_EN_TWO = 8'hF3;
  localparam logic [7:0] IDX_STATUS     = 8'hF4;
  localparam logic [7:0] IDX_MASK       = 8'hF5;
  localparam logic [7:0] IDX_GP_EN1_LO  = 8'hF6;
  localparam logic [7:0] IDX_GP_EN1_HI  = 8'hF7;
  localparam logic [7:0] IDX_GP_EN2     = 8'hF8;
  localparam logic [7:0] IDX_PIN_STEER  = 8'hF9;
  localparam logic [7:0] IDX_ALT_FUNC   = 8'hFA;
  localparam logic [7:0] IDX_ALARM_MODE = 8'hFB;
  // watchdog_power_control bits
  localparam int WDC_RESTART = 6;
  localparam int WDC_SOFTWARE_POWER_OFF_BIT   = 7;
  // soft_power_enable_two bits
  localparam int SPE2_PWRGOOD = 6;
  localparam int SPE2_OFF_EN  = 7;
  // status / enable / mask bit positions
  localparam int EV_BUTTON = 0;
  localparam int EV_RI1    = 1;
  localparam int EV_RI2    = 2;
  localparam int EV_RXD1   = 3;
  localparam int EV_RXD2   = 4;
  localparam int EV_KBD    = 5;
  localparam int EV_MOUSE  = 6;
  localparam int EV_INFRARED_RECEIVE_TWO  = 7;
  localparam int EV_ALARM1 = 8;
  localparam int EV_ALARM2 = 9;
  localparam int EV_GINT1  = 10;
  localparam int EV_GINT2  = 11;
  localparam int EV_OFF    = 12;
  localparam int EV_W      = 13;
  // reset values
  localparam logic [7:0]  RST_OFF_DELAY = 8'h05;
  localparam logic [15:0] RST_ENABLE    = 16'h0001;
  localparam logic [7:0]  RST_SPE2      = 8'h80;
  // off-delay unit: one second at 100 MHz
  localparam longint OFF_UNIT_NS = 1000000000;
  localparam longint CLK_NS      = 10;
  localparam longint OFF_UNIT_CYC = OFF_UNIT_NS / CLK_NS;
  // alarm one repetition modes
  typedef enum logic [2:0] {
    AM_ONCE, AM_MINUTE, AM_HOUR, AM_DAY, AM_WEEK, AM_MONTH, AM_YEAR
  } spw_alarm_mode_t;
  // pin inputs that cross into the clock domain
  typedef struct packed {
    logic        button_n;
    logic [1:0]  ring_n;
    logic [1:0]  rxd;
    logic        kbd_clk;
    logic        mouse_clk;
    logic        infrared_receive_two;
    logic [1:0]  alarm;
    logic [5:0]  rtc_tick;
    logic        irq_input_pin_a;
    logic        irq_input_pin_b;
    logic        supply_on_sense;
    logic [63:0] gp_in;
  } spw_pins_t;
endpackage : spw_pkg

// ==== hw/spw_ctrl.sv ====
// soft power management, wake-up and group interrupt steering
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module spw_ctrl
  import spw_pkg::*;
#(
  parameter longint UNIT_CYC = OFF_UNIT_CYC,
  parameter int     IRQ_N    = 16
) (
  input  wire logic              clk,          // 100 MHz standby clock
  input  wire logic              rst_b,        // async reset, active low
  input  wire logic [11:0]       paddr,        // apb byte address
  input  wire logic              psel,         // apb select
  input  wire logic              penable,      // apb access phase
  input  wire logic              pwrite,       // apb direction
  input  wire logic [31:0]       pwdata,       // apb write data
  output logic [31:0]            prdata,       // apb read data
  output logic                   pready,       // apb ready
  output logic                   pslverr,      // unmapped address
  input  wire spw_pins_t         pins,         // asynchronous pin inputs
  output logic                   supply_on_control_n_o,  // pin level
  output logic                   supply_on_control_n_oe, // pulls low
  output logic [IRQ_N-1:0]       irq_out,      // steered irq lines
  output logic                   group_irq_one, // group interrupt one
  output logic                   group_irq_two, // group interrupt two
  output logic [7:0]             alt_func_sel, // port group functions
  output logic                   blocks_enable, // functional blocks on
  output logic                   wake_request, // power-on request
  output logic                   spw_irq       // status interrupt
);

  // power states; code 3 cannot be reached and falls back to off
  typedef enum logic [1:0] {PS_OFF, PS_ON, PS_DELAY} spw_pstate_t;

  // every flop of the block in one word
  typedef struct packed {
    spw_pins_t        s1;
    spw_pins_t        s2;
    spw_pins_t        prev;
    logic             g1_prev;
    logic             g2_prev;
    logic [7:0]       off_delay;
    logic [7:0]       steer_one;
    logic [7:0]       steer_two;
    logic [7:0]       spe2;
    logic [15:0]      enable;
    logic [15:0]      status;
    logic [15:0]      mask;
    logic [63:0]      gp_en1;
    logic [31:0]      gp_en2;
    logic [7:0]       pin_steer;
    logic [7:0]       alt_func;
    spw_alarm_mode_t  alarm_mode;
    logic             alarm_armed;
    logic [31:0]      rdata;
    spw_pstate_t      pstate;
    logic [63:0]      unit_cnt;
    logic [7:0]       units;
    logic             drive_low;
    logic [IRQ_N-1:0] irq;
    logic             g1;
    logic             g2;
  } spw_state_t;

  spw_state_t st_reg;
  spw_state_t st_next;

  // one-hot irq line from a 4-bit selector; zero means not routed
  // selectors past the last line are dropped, not wrapped
  function automatic logic [IRQ_N-1:0] steer(input logic [3:0] sel,
                                             input logic       lvl);
    logic [IRQ_N-1:0] v;
    v = '0;
    if (lvl && sel != 4'h0 && int'(sel) < IRQ_N) begin
      v[sel] = 1'b1;
    end
    return v;
  endfunction : steer

  // falling edge between two sampled levels
  // both levels are synchronised, so no glitch edges
  function automatic logic fall(input logic now, input logic was);
    return was & ~now;
  endfunction : fall

  // decode, event and divider wires
  logic              acc;
  logic              wr;
  logic              rd;
  logic [7:0]        idx;
  logic              mapped;
  logic [EV_W-1:0]   ev;
  logic [15:0]       ev16;
  logic              wdc_wr;
  logic              pgood_low;
  logic              gl1;
  logic              gl2;
  logic              alarm1_hit;
  logic              btn_press;
  logic              wake_any;
  logic              unit_tick;
  logic [63:0]       gp_lvl;

  // bus decode; reads finish in the access cycle from a flopped word
  // pready follows penable: every access ends in its first cycle
  // and the read mux stays off the prdata path
  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;
  assign idx    = paddr[9:2];
  assign pready = penable;
  assign mapped = (idx == IDX_OFF_DELAY) || (idx >= IDX_STEER_TWO &&
                  idx <= IDX_ALARM_MODE);
  assign pslverr = acc & (~mapped | paddr[11:10] != 2'b00);
  assign wdc_wr  = wr & mapped & idx == IDX_WDOG_CTRL & ~pslverr;

  // power-good mode with the supply pin floating high
  // the pull-up makes a released pin read as not good
  assign pgood_low = st_reg.spe2[SPE2_PWRGOOD] &
                     st_reg.s2.supply_on_sense;

  // group interrupt levels from enabled gpio pins
  // group two sees only port groups four to seven
  assign gp_lvl = st_reg.s2.gp_in;
  assign gl1 = |(gp_lvl & st_reg.gp_en1);
  assign gl2 = |(gp_lvl[63:32] & st_reg.gp_en2);

  // alarm one: its own match or the selected periodic tick
  // periodic modes never disarm; code 7 never matches
  always_comb begin
    unique case (st_reg.alarm_mode)
      AM_ONCE:   alarm1_hit = st_reg.alarm_armed &
                   ~st_reg.prev.alarm[0] & st_reg.s2.alarm[0];
      AM_MINUTE: alarm1_hit = ~st_reg.prev.rtc_tick[0] &
                   st_reg.s2.rtc_tick[0];
      AM_HOUR:   alarm1_hit = ~st_reg.prev.rtc_tick[1] &
                   st_reg.s2.rtc_tick[1];
      AM_DAY:    alarm1_hit = ~st_reg.prev.rtc_tick[2] &
                   st_reg.s2.rtc_tick[2];
      AM_WEEK:   alarm1_hit = ~st_reg.prev.rtc_tick[3] &
                   st_reg.s2.rtc_tick[3];
      AM_MONTH:  alarm1_hit = ~st_reg.prev.rtc_tick[4] &
                   st_reg.s2.rtc_tick[4];
      AM_YEAR:   alarm1_hit = ~st_reg.prev.rtc_tick[5] &
                   st_reg.s2.rtc_tick[5];
      default:   alarm1_hit = 1'b0;
    endcase
  end

  // wake events; prev clears at reset so a level held by alarm two
  // across a power loss shows as an edge once standby returns
  always_comb begin
    ev = '0;
    ev[EV_BUTTON] = fall(st_reg.s2.button_n, st_reg.prev.button_n);
    ev[EV_RI1]    = fall(st_reg.s2.ring_n[0], st_reg.prev.ring_n[0]);
    ev[EV_RI2]    = fall(st_reg.s2.ring_n[1], st_reg.prev.ring_n[1]);
    ev[EV_RXD1]   = fall(st_reg.s2.rxd[0], st_reg.prev.rxd[0]);
    ev[EV_RXD2]   = fall(st_reg.s2.rxd[1], st_reg.prev.rxd[1]);
    ev[EV_KBD]    = fall(st_reg.s2.kbd_clk, st_reg.prev.kbd_clk);
    ev[EV_MOUSE]  = fall(st_reg.s2.mouse_clk, st_reg.prev.mouse_clk);
    ev[EV_INFRARED_RECEIVE_TWO]  = fall(st_reg.s2.infrared_receive_two,
                         st_reg.prev.infrared_receive_two);
    ev[EV_ALARM1] = alarm1_hit;
    ev[EV_ALARM2] = st_reg.s2.alarm[1] & ~st_reg.prev.alarm[1];
    ev[EV_GINT1]  = st_reg.g1 & ~st_reg.g1_prev;
    ev[EV_GINT2]  = st_reg.g2 & ~st_reg.g2_prev;
    // widened to the status layout; bit 12 is set elsewhere
    ev16 = {{(16 - EV_W){1'b0}}, ev};
  end

  // a press is the synchronised falling edge
  assign btn_press = ev[EV_BUTTON];
  // a pending enabled status bit other than bit 12 asks for power; stale bits would
  // re-wake at once, which is why software reads status first
  assign wake_any = |(st_reg.status[EV_W-2:0] &
                      st_reg.enable[EV_W-2:0]);
  // one pulse per off-delay unit
  assign unit_tick = st_reg.unit_cnt == 64'(UNIT_CYC - 1);

  // next state of everything
  always_comb begin
    st_next = st_reg;
    // two-flop synchronisers, then edge history
    // only s2 and prev feed logic, never the first flop
    st_next.s1   = pins;
    st_next.s2   = st_reg.s1;
    st_next.prev = st_reg.s2;
    st_next.g1      = gl1;
    st_next.g2      = gl2;
    st_next.g1_prev = st_reg.g1;
    st_next.g2_prev = st_reg.g2;
    // a once alarm fires once until the mode is rewritten
    if (alarm1_hit && st_reg.alarm_mode == AM_ONCE) begin
      st_next.alarm_armed = 1'b0;
    end

    // register writes
    // status is read-only; control writes act as commands
    if (wr && !pslverr) begin
      unique case (idx)
        IDX_OFF_DELAY:  st_next.off_delay = pwdata[7:0];
        IDX_STEER_TWO:  st_next.steer_two = pwdata[7:0];
        IDX_STEER_ONE:  st_next.steer_one = pwdata[7:0];
        IDX_SPW_EN_ONE: st_next.enable    = pwdata[15:0];
        IDX_SPW_EN_TWO: st_next.spe2      = pwdata[7:0];
        IDX_MASK:       st_next.mask      = pwdata[15:0];
        IDX_GP_EN1_LO:  st_next.gp_en1[31:0]  = pwdata;
        IDX_GP_EN1_HI:  st_next.gp_en1[63:32] = pwdata;
        IDX_GP_EN2:     st_next.gp_en2    = pwdata;
        IDX_PIN_STEER:  st_next.pin_steer = pwdata[7:0];
        IDX_ALT_FUNC:   st_next.alt_func  = pwdata[7:0];
        IDX_ALARM_MODE: begin
          st_next.alarm_mode  = spw_alarm_mode_t'(pwdata[2:0]);
          st_next.alarm_armed = 1'b1;
        end
        default: ;
      endcase
    end

    // read word captured in the setup cycle
    // power state word reads 0 off, 1 on, 2 delay
    if (psel && !penable) begin
      unique case (idx)
        IDX_OFF_DELAY:  st_next.rdata = {24'h0, st_reg.off_delay};
        IDX_STEER_TWO:  st_next.rdata = {24'h0, st_reg.steer_two};
        IDX_STEER_ONE:  st_next.rdata = {24'h0, st_reg.steer_one};
        IDX_WDOG_CTRL:  st_next.rdata = {30'h0, st_reg.pstate};
        IDX_SPW_EN_ONE: st_next.rdata = {16'h0, st_reg.enable};
        IDX_SPW_EN_TWO: st_next.rdata = {24'h0, st_reg.spe2};
        IDX_STATUS:     st_next.rdata = {16'h0, st_reg.status | ev16};
        IDX_MASK:       st_next.rdata = {16'h0, st_reg.mask};
        IDX_GP_EN1_LO:  st_next.rdata = st_reg.gp_en1[31:0];
        IDX_GP_EN1_HI:  st_next.rdata = st_reg.gp_en1[63:32];
        IDX_GP_EN2:     st_next.rdata = st_reg.gp_en2;
        IDX_PIN_STEER:  st_next.rdata = {24'h0, st_reg.pin_steer};
        IDX_ALT_FUNC:   st_next.rdata = {24'h0, st_reg.alt_func};
        IDX_ALARM_MODE: st_next.rdata = {29'h0, st_reg.alarm_mode};
        default:        st_next.rdata = 32'h0;
      endcase
    end

    // reads outside the register window return zero
    if (psel && !penable && paddr[11:10] != 2'b00) begin
      st_next.rdata = 32'h0;
    end

    // read of status clears it; new events in that cycle survive
    // so only an off completion in the setup cycle can slip between a read and its clear
    if (rd && !pslverr && idx == IDX_STATUS) begin
      st_next.status = 16'h0;
    end
    st_next.status = st_next.status | ev16;

    // off-delay unit divider runs only while a delay is pending
    // and restarts from zero on every reload
    if (st_reg.pstate == PS_DELAY && !unit_tick) begin
      st_next.unit_cnt = st_reg.unit_cnt + 64'h1;
    end else begin
      st_next.unit_cnt = 64'h0;
    end

    // power sequence
    // bit 7 powers off when on but stops a pending delay,
    // so a single write never starts and cancels a delay
    unique case (st_reg.pstate)
      PS_OFF: begin
        // the button powers on even with its wake disabled
        if (btn_press || wake_any) begin
          st_next.pstate = PS_ON;
        end
      end
      PS_ON: begin
        // software bit or an enabled button starts the delay
        if ((wdc_wr && pwdata[WDC_SOFTWARE_POWER_OFF_BIT]) ||
            (btn_press && st_reg.spe2[SPE2_OFF_EN])) begin
          st_next.pstate   = PS_DELAY;
          st_next.units    = st_reg.off_delay;
          st_next.unit_cnt = 64'h0;
        end
      end
      PS_DELAY: begin
        if (wdc_wr && pwdata[WDC_SOFTWARE_POWER_OFF_BIT]) begin
          st_next.pstate = PS_ON;
        end else if (wdc_wr && pwdata[WDC_RESTART]) begin
          // a restart reloads the full count, extending the delay
          st_next.units    = st_reg.off_delay;
          st_next.unit_cnt = 64'h0;
        end else if (st_reg.units == 8'h0) begin
          st_next.pstate = PS_OFF;
          // completion is itself an event for software
          st_next.status[EV_OFF] = 1'b1;
        end else if (unit_tick) begin
          st_next.units = st_reg.units - 8'h1;
        end
      end
      default: st_next.pstate = PS_OFF;
    endcase
    // pin pulls the supply on in every state but off
    st_next.drive_low = st_next.pstate != PS_OFF;

    // irq steering, silenced while the chip is not powered good
    // steered group irqs lag their pins by four edges; group_irq_one and group_irq_two by three
    st_next.irq = '0;
    if (!pgood_low) begin
      st_next.irq = steer(st_reg.steer_one[3:0], st_reg.g1) |
                    steer(st_reg.steer_two[3:0], st_reg.g2);
      st_next.irq = st_next.irq |
        steer(st_reg.pin_steer[3:0], st_reg.s2.irq_input_pin_a) |
        steer(st_reg.pin_steer[7:4], st_reg.s2.irq_input_pin_b);
    end
  end

  // state register; standby power return starts with supply off
  // a released button reads high, so its history resets high;
  // a low reset value would hide a press held across reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg            <= '0;
      st_reg.s1.button_n <= 1'b1;
      st_reg.s2.button_n <= 1'b1;
      st_reg.prev.button_n <= 1'b1;
      st_reg.s1.ring_n  <= 2'h3;
      st_reg.s2.ring_n  <= 2'h3;
      st_reg.prev.ring_n <= 2'h3;
      st_reg.off_delay  <= RST_OFF_DELAY;
      st_reg.enable     <= RST_ENABLE;
      st_reg.spe2       <= RST_SPE2;
      st_reg.alarm_armed <= 1'b1;
      st_reg.pstate     <= PS_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs; the supply pin only ever pulls low
  // level is tied low and only the enable moves
  assign prdata                 = st_reg.rdata;
  assign supply_on_control_n_o  = 1'b0;
  assign supply_on_control_n_oe = st_reg.drive_low;
  assign irq_out       = st_reg.irq;
  assign group_irq_one = st_reg.g1;
  assign group_irq_two = st_reg.g2;
  assign alt_func_sel  = pgood_low ? 8'h00 : st_reg.alt_func;
  assign blocks_enable = ~pgood_low;
  assign wake_request  = wake_any;
  assign spw_irq       = |(st_reg.status & st_reg.mask);

endmodule : spw_ctrl
`default_nettype wire

// ==== tb/spw_ctrl_props.sv ====
// port-level assertions for the soft power wake-up block
`timescale 1ns/1ns
`default_nettype none
module spw_ctrl_props
  import spw_pkg::*;
#(
  parameter int IRQ_N = 16
) (
  input wire logic             clk,                    // clock
  input wire logic             rst_b,                  // reset, active low
  input wire logic [11:0]      paddr,                  // apb address
  input wire logic             psel,                   // apb select
  input wire logic             penable,                // apb access
  input wire logic             pwrite,                 // apb direction
  input wire logic [31:0]      pwdata,                 // apb write data
  input wire logic [31:0]      prdata,                 // apb read data
  input wire logic             pready,                 // apb ready
  input wire logic             pslverr,                // apb error
  input wire logic             supply_on_control_n_o,  // pin level
  input wire logic             supply_on_control_n_oe, // pin pulled low
  input wire logic [IRQ_N-1:0] irq_out,                // steered irqs
  input wire logic [7:0]       alt_func_sel,           // alt functions
  input wire logic             blocks_enable,          // blocks on
  input wire logic             wake_request,           // wake request
  input wire logic             spw_irq                 // status irq
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);

  // zero wait states, so access phase always answers at once
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("apb access without ready");
  // addresses above the register window are refused with zero data
  high_addr_a: assert property (psel && penable && paddr[11:10] != 2'b00
    |-> pslverr && prdata == 32'h0) else $error("high address accepted");
  // read data stands until a new setup cycle captures the next word
  rdata_stand_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  // open collector: the pin is only ever pulled low
  drive_low_a: assert property (supply_on_control_n_o == 1'b0)
    else $error("supply pin driven high");
  // an enabled wake while off turns the supply on quickly
  wake_on_a: assert property (
    wake_request && !supply_on_control_n_oe |-> ##[1:3] supply_on_control_n_oe)
    else $error("wake did not power on");
  // a power-off write while on keeps the supply on for the next two cycles
  off_delay_a: assert property (
    psel && penable && pwrite && paddr[9:2] == IDX_WDOG_CTRL &&
    pwdata[WDC_SOFTWARE_POWER_OFF_BIT] && supply_on_control_n_oe |=> supply_on_control_n_oe[*2])
    else $error("supply dropped without delay");
  // quiesced chip releases alternate pin functions
  pg_quiet_a: assert property (
    !blocks_enable |-> alt_func_sel == 8'h00)
    else $error("alternate functions active while quiesced");
  // a status read clears what it returned
  status_clear_a: assert property (
    psel && penable && !pwrite && paddr[11:2] == {2'b00, IDX_STATUS}
    |=> !spw_irq && !wake_request) else $error("status not cleared by read");
endmodule : spw_ctrl_props
`default_nettype wire

// ==== tb/spw_supply_model.sv ====
// behavioural power supply and front-panel button
`timescale 1ns/1ns
`default_nettype none
module spw_supply_model (
  input  wire logic supply_on_control_n_oe, // block pulls pin low
  input  wire logic press,                  // finger on the button
  output logic      button_n,               // pulled-up button line
  output logic      supply_on_sense         // level seen on supply pin
);
  // pin has a pull-up, so a released pin reads high
  assign supply_on_sense = ~supply_on_control_n_oe;
  // button shorts its pulled-up line to ground
  assign button_n = ~press;
endmodule : spw_supply_model
`default_nettype wire

// ==== tb/test_spw_ctrl.sv ====
// self-checking bench for the soft power wake-up block
`timescale 1ns/1ns
`default_nettype none
module test_spw_ctrl;
  import spw_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, press, pin_a;
  logic [11:0] paddr;
  logic [63:0] gp;
  logic [5:0]  tick;
  logic [1:0]  hi;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sup_o, sup_oe, gi1, gi2, blk_en, wake, irq;
  logic        btn_n, sense;
  logic [15:0] irq_out;
  logic [7:0]  alt;
  spw_pins_t   pins;
  int          fails = 0;
  int          tests_run = 0;

  // idle levels on wake lines but the button and rtc ticks; gpio and ticks driven by the event test
  assign pins = '{button_n: btn_n, ring_n: 2'b11, rxd: 2'b11, kbd_clk: 1'b1,
    mouse_clk: 1'b1, infrared_receive_two: 1'b1, alarm: 2'b00,
    rtc_tick: tick, irq_input_pin_a: pin_a, irq_input_pin_b: 1'b0,
    supply_on_sense: sense, gp_in: gp};

  spw_supply_model u_sup (.supply_on_control_n_oe(sup_oe), .press(press),
    .button_n(btn_n), .supply_on_sense(sense));
  spw_ctrl #(.UNIT_CYC(4), .IRQ_N(16)) uut (.clk(clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .supply_on_control_n_o(sup_o),
    .supply_on_control_n_oe(sup_oe), .irq_out(irq_out),
    .group_irq_one(gi1), .group_irq_two(gi2), .alt_func_sel(alt),
    .blocks_enable(blk_en), .wake_request(wake), .spw_irq(irq));

  // clock and hang guard
  initial clk = 1'b0;
  always #5 clk = ~clk;
  initial begin
    #50000;
    fails = fails + 1;
    tally_and_finish();
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until ready is sampled
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {hi, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(nm, exp, r);
  endtask : rdc

  // press long enough to pass the synchronisers, then let go
  task push();
    @(posedge clk);
    press <= 1'b1;
    repeat (8) @(posedge clk);
    press <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : push

  task wait_oe(input logic v);
    for (int i = 0; i < 60 && sup_oe !== v; i++) @(posedge clk);
  endtask : wait_oe

  task t_reset();
    logic [31:0] r;
    logic e;
    rdc("off_delay", IDX_OFF_DELAY, 32'h5);
    rdc("spe2", IDX_SPW_EN_TWO, 32'h80);
    rdc("state_off", IDX_WDOG_CTRL, 32'h0);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    hi <= 2'b01;
    apb(1'b0, IDX_OFF_DELAY, 32'h0, r, e);
    hi <= 2'b00;
    chk("high_err", 32'h1, {31'h0, e});
    chk("high_data", 32'h0, r);
    $display("test reset done");
  endtask : t_reset

  task t_power_on();
    wr(IDX_MASK, 32'h1);
    push();
    wait_oe(1'b1);
    chk("supply_on", 32'h1, {31'h0, sup_oe});
    chk("irq_raised", 32'h1, {31'h0, irq});
    rdc("status_btn", IDX_STATUS, 32'h1);
    @(posedge clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rdc("state_on", IDX_WDOG_CTRL, 32'h1);
    $display("test power_on done");
  endtask : t_power_on

  task t_steer();
    wr(IDX_STEER_ONE, 32'h3);
    rdc("steer_one", IDX_STEER_ONE, 32'h3);
    wr(IDX_STEER_TWO, 32'h4);
    rdc("steer_two", IDX_STEER_TWO, 32'h4);
    wr(IDX_PIN_STEER, 32'h5);
    pin_a <= 1'b1;
    repeat (6) @(posedge clk);
    chk("pin_a_routed", 32'h20, {16'h0, irq_out});
    pin_a <= 1'b0;
    repeat (6) @(posedge clk);
    chk("pin_a_low", 32'h0, {16'h0, irq_out});
    $display("test steer done");
  endtask : t_steer

  task t_events();
    wr(IDX_GP_EN1_LO, 32'h1);
    wr(IDX_GP_EN2, 32'hFFFFFFFF);
    wr(IDX_ALARM_MODE, 32'h1);
    gp <= 64'h0000_0000_FFFF_FFFF;
    tick <= 6'h01;
    repeat (6) @(posedge clk);
    chk("group_one", 32'h1, {31'h0, gi1});
    chk("group_two_low", 32'h0, {31'h0, gi2});
    chk("group_one_irq", 32'h8, {16'h0, irq_out});
    gp <= 64'h0000_0001_0000_0000;
    repeat (6) @(posedge clk);
    chk("group_two", 32'h1, {31'h0, gi2});
    chk("group_two_irq", 32'h10, {16'h0, irq_out});
    gp <= 64'h0;
    tick <= 6'h00;
    rdc("status_events", IDX_STATUS, 32'hD00);
    $display("test events done");
  endtask : t_events

  // button off is gated; masked event raises no interrupt
  task t_button_gated();
    wr(IDX_SPW_EN_TWO, 32'h0);
    wr(IDX_MASK, 32'h0);
    push();
    repeat (4) @(posedge clk);
    rdc("still_on", IDX_WDOG_CTRL, 32'h1);
    chk("masked_irq", 32'h0, {31'h0, irq});
    rdc("status_btn2", IDX_STATUS, 32'h1);
    wr(IDX_SPW_EN_TWO, 32'h80);
    $display("test button_gated done");
  endtask : t_button_gated

  task t_soft_off();
    int n;
    wr(IDX_ALT_FUNC, 32'h3C);
    wr(IDX_OFF_DELAY, 32'h8);
    wr(IDX_WDOG_CTRL, 32'h80);
    rdc("state_delay", IDX_WDOG_CTRL, 32'h2);
    wr(IDX_WDOG_CTRL, 32'h80);
    rdc("state_stopped", IDX_WDOG_CTRL, 32'h1);
    wr(IDX_OFF_DELAY, 32'h3);
    wr(IDX_WDOG_CTRL, 32'h80);
    repeat (6) @(posedge clk);
    wr(IDX_WDOG_CTRL, 32'h40);
    for (n = 0; n < 40 && sup_oe !== 1'b0; n++) @(posedge clk);
    chk("restart_len", 32'h1, {31'h0, n >= 9 && n <= 18});
    chk("supply_off", 32'h0, {31'h0, sup_oe});
    rdc("status_off", IDX_STATUS, 32'h1000);
    $display("test soft_off done");
  endtask : t_soft_off

  // supply pin floats while off, so power-good mode quiesces the chip
  task t_power_good();
    wr(IDX_SPW_EN_TWO, 32'hC0);
    repeat (5) @(posedge clk);
    chk("pg_blocks", 32'h0, {31'h0, blk_en});
    chk("pg_alt", 32'h0, {24'h0, alt});
    wr(IDX_SPW_EN_TWO, 32'h80);
    repeat (5) @(posedge clk);
    chk("blocks_back", 32'h1, {31'h0, blk_en});
    chk("alt_back", 32'h3C, {24'h0, alt});
    $display("test power_good done");
  endtask : t_power_good

  task tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    press = 1'b0;
    pin_a = 1'b0;
    gp = 64'h0;
    tick = 6'h00;
    hi = 2'b00;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_power_on();
    t_steer();
    t_events();
    t_button_gated();
    t_soft_off();
    t_power_good();
    tally_and_finish();
  end
endmodule : test_spw_ctrl

bind spw_ctrl spw_ctrl_props #(.IRQ_N(IRQ_N)) u_props (.clk(clk),
  .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .supply_on_control_n_o(supply_on_control_n_o),
  .supply_on_control_n_oe(supply_on_control_n_oe), .irq_out(irq_out),
  .alt_func_sel(alt_func_sel), .blocks_enable(blocks_enable),
  .wake_request(wake_request), .spw_irq(spw_irq));
`default_nettype wire
